//--- rtl/overhead_data_in_regs.svh
// What this block does
// - in nibble mode with HDLC off sample nibble line 3 on each nibble clock rise
// - ignore nibble line 3 when nibble mode is not selected
// - hand sampled nibble bits to the payload positions of the frame
// - with HDLC on, the nibble line 3 pin is HDLC byte bit 3
// - with HDLC on, the insert request pin is HDLC byte bit 4
// - raise overhead clock one bit period before each overhead bit
// - sample overhead data at overhead clock fall when insert is high
// - with insert request low, overhead data is never sampled
// - overhead clock pulses for every overhead bit, insertable or not
// - insert on a non-insertable bit is ignored, bit stays internal
// - an accepted bit goes to its position in the very next frame
`ifndef OVERHEAD_DATA_IN_REGS_SVH
`define OVERHEAD_DATA_IN_REGS_SVH

// =============================================================
// sizes
`define OVERHEAD_DATA_IN_SLOTS 56
`define OVERHEAD_DATA_IN_IDX_W 6

// =============================================================
// timing
`define OVERHEAD_DATA_IN_CLK_NS 50
`define OVERHEAD_DATA_IN_BIT_NS 400
`define OVERHEAD_DATA_IN_BIT_CYC (`OVERHEAD_DATA_IN_BIT_NS / `OVERHEAD_DATA_IN_CLK_NS)
`define OVERHEAD_DATA_IN_HALF_CYC (`OVERHEAD_DATA_IN_BIT_CYC / 2)

// =============================================================
// reset values
`define OVERHEAD_DATA_IN_CLK_RST 1'h0

`endif

//--- rtl/overhead_data_in_pkg.sv
`include "overhead_data_in_regs.svh"

package overhead_data_in_pkg;

	// =============================================================
	// overhead clock sequencer
	typedef enum logic [1:0] {
		OVERHEAD_DATA_IN_IDLE = 2'b00,
		OVERHEAD_DATA_IN_HIGH = 2'b01,
		OVERHEAD_DATA_IN_LOW = 2'b10
	} overhead_data_in_state_e;

	typedef logic [`OVERHEAD_DATA_IN_IDX_W-1:0] overhead_data_in_idx_t;

	// =============================================================
	// core side carriers
	// warning one bit period ahead of an overhead bit
	typedef struct packed {
		logic valid;
		logic insertable;
		overhead_data_in_idx_t idx;
	} overhead_data_in_warn_s;

	// core is processing an overhead bit now
	typedef struct packed {
		logic valid;
		logic internal_bit;
		overhead_data_in_idx_t idx;
	} overhead_data_in_proc_s;

	typedef struct packed {
		logic valid;
		logic bit_val;
	} overhead_data_in_oh_s;

	typedef struct packed {
		logic valid;
		logic bit3;
	} overhead_data_in_pay_s;

	typedef struct packed {
		logic bit3;
		logic bit4;
	} overhead_data_in_hdlc_s;

endpackage

//--- rtl/overhead_data_in_sync.sv
module overhead_data_in_sync #(
	parameter int W = 4
) (
	// clock and control
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	// asynchronous pins
	input wire logic [W-1:0] din,
	// synchronised view
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// first stage feeds only the second stage
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					meta[i] <= 1'h0;
					level[i] <= 1'h0;
					prev[i] <= 1'h0;
				end else if (ce) begin
					meta[i] <= din[i];
					level[i] <= meta[i];
					prev[i] <= level[i];
				end
			end
			assign rise[i] = ce & level[i] & ~prev[i];
			assign fall[i] = ce & ~level[i] & prev[i];
		end
	endgenerate

endmodule

//--- rtl/overhead_data_in_port.sv
`include "overhead_data_in_regs.svh"

module overhead_data_in_port (
	// clock and control
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	// mode selection from the framer configuration
	input wire logic nibble_mode,
	input wire logic hdlc_enable,
	// pins from the terminal equipment
	input wire logic nibble_sample_clock,
	input wire logic payload_nibble_line3,
	input wire logic overhead_insert_request,
	input wire logic overhead_data_in,
	// pin to the terminal equipment
	output logic overhead_slot_clock,
	// framer core side
	input wire overhead_data_in_pkg::overhead_data_in_warn_s oh_warn,
	input wire overhead_data_in_pkg::overhead_data_in_proc_s oh_proc,
	input wire logic frame_start,
	output overhead_data_in_pkg::overhead_data_in_oh_s oh_tx,
	output overhead_data_in_pkg::overhead_data_in_pay_s pay_out,
	output overhead_data_in_pkg::overhead_data_in_hdlc_s hdlc_out
);
	import overhead_data_in_pkg::*;

	localparam int HALF = `OVERHEAD_DATA_IN_HALF_CYC;
	localparam logic [3:0] HALF_LAST = 4'(HALF - 1);
	localparam int SLOTS = `OVERHEAD_DATA_IN_SLOTS;

	// =============================================================
	// pin synchronisers
	logic [3:0] pin_lvl;
	logic [3:0] pin_rise;
	logic nib_clk_rise;
	logic nib3_s;
	logic ins_s;
	logic dat_s;

	overhead_data_in_sync #(.W(4)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.din({overhead_data_in, overhead_insert_request,
			payload_nibble_line3, nibble_sample_clock}),
		.level(pin_lvl),
		.rise(pin_rise),
		.fall()
	);

	assign nib_clk_rise = pin_rise[0];
	assign nib3_s = pin_lvl[1];
	assign ins_s = pin_lvl[2];
	assign dat_s = pin_lvl[3];

	function automatic logic idx_hit(input overhead_data_in_idx_t idx, input int slot);
		idx_hit = (idx == overhead_data_in_idx_t'(slot));
	endfunction

	// =============================================================
	// payload nibble line 3
	logic nib_active;
	// the shared pin belongs to HDLC once the controller is on
	assign nib_active = nibble_mode & ~hdlc_enable;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pay_out <= '0;
		end else if (ce) begin
			pay_out.valid <= nib_clk_rise & nib_active;
			if (nib_clk_rise & nib_active) begin
				pay_out.bit3 <= nib3_s;
			end
		end
	end

	// =============================================================
	// HDLC byte bits on shared pins
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hdlc_out <= '0;
		end else if (ce) begin
			if (hdlc_enable) begin
				hdlc_out.bit3 <= nib3_s;
				hdlc_out.bit4 <= ins_s;
			end
		end
	end

	// =============================================================
	// overhead slot clock
	overhead_data_in_state_e state;
	logic [3:0] cnt;
	overhead_data_in_idx_t cur_idx;
	logic cur_ins;
	logic fall_now;
	logic take_warn;

	// a warning during the high phase would reload the count and stretch the pulse, so it is ignored
	assign take_warn = ce & oh_warn.valid & (state != OVERHEAD_DATA_IN_HIGH);
	assign fall_now = ce & (state == OVERHEAD_DATA_IN_HIGH) & (cnt == 4'h0);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= OVERHEAD_DATA_IN_IDLE;
			cnt <= 4'h0;
			overhead_slot_clock <= `OVERHEAD_DATA_IN_CLK_RST;
		end else if (ce) begin
			case (state)
			OVERHEAD_DATA_IN_IDLE, OVERHEAD_DATA_IN_LOW: begin
				if (take_warn) begin
					state <= OVERHEAD_DATA_IN_HIGH;
					cnt <= HALF_LAST;
					overhead_slot_clock <= 1'h1;
				end else if (state == OVERHEAD_DATA_IN_LOW) begin
					if (cnt == 4'h0) begin
						state <= OVERHEAD_DATA_IN_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
			end
			OVERHEAD_DATA_IN_HIGH: begin
				if (cnt == 4'h0) begin
					state <= OVERHEAD_DATA_IN_LOW;
					cnt <= HALF_LAST;
					overhead_slot_clock <= 1'h0;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			default: begin
				state <= OVERHEAD_DATA_IN_IDLE;
				overhead_slot_clock <= 1'h0;
			end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cur_idx <= '0;
			cur_ins <= 1'h0;
		end else if (take_warn) begin
			cur_idx <= oh_warn.idx;
			cur_ins <= oh_warn.insertable;
		end
	end

	// =============================================================
	// capture and frame staging
	logic cap;
	// insert pin is HDLC data while the controller runs
	assign cap = fall_now & ins_s & cur_ins & ~hdlc_enable;

	logic [SLOTS-1:0] staged_vld;
	logic [SLOTS-1:0] staged_val;
	logic [SLOTS-1:0] armed_vld;
	logic [SLOTS-1:0] armed_val;

	genvar s;
	generate
		for (s = 0; s < SLOTS; s++) begin : g_slot
			// a capture in the frame start cycle still lands in the new
			// frame's stage, so it is never lost
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					staged_vld[s] <= 1'h0;
					staged_val[s] <= 1'h0;
				end else if (ce) begin
					if (cap & idx_hit(cur_idx, s)) begin
						staged_vld[s] <= 1'h1;
						staged_val[s] <= dat_s;
					end else if (frame_start) begin
						staged_vld[s] <= 1'h0;
					end
				end
			end
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					armed_vld[s] <= 1'h0;
					armed_val[s] <= 1'h0;
				end else if (ce) begin
					if (frame_start) begin
						armed_vld[s] <= staged_vld[s];
						armed_val[s] <= staged_val[s];
					end else if (oh_proc.valid & idx_hit(oh_proc.idx, s)) begin
						armed_vld[s] <= 1'h0;
					end
				end
			end
		end
	endgenerate

	// =============================================================
	// overhead bit to the framer core
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			oh_tx <= '0;
		end else if (ce) begin
			oh_tx.valid <= oh_proc.valid;
			if (oh_proc.valid) begin
				if (armed_vld[oh_proc.idx]) begin
					oh_tx.bit_val <= armed_val[oh_proc.idx];
				end else begin
					oh_tx.bit_val <= oh_proc.internal_bit;
				end
			end
		end
	end

	// =============================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	chk_nib_sample: assert property (
		nib_clk_rise && nib_active |=> pay_out.valid
			&& pay_out.bit3 == $past(nib3_s))
		else $error("nibble line 3 not sampled on clock rise");

	chk_nib_ignore: assert property (
		pay_out.valid |-> $past(nibble_mode) && !$past(hdlc_enable))
		else $error("nibble sample outside nibble mode");

	chk_hdlc_bit3: assert property (
		ce && hdlc_enable ##1 ce && hdlc_enable |->
			hdlc_out.bit3 == $past(nib3_s))
		else $error("HDLC bit 3 does not follow shared pin");

	chk_hdlc_bit4: assert property (
		ce && hdlc_enable |=> hdlc_out.bit4 == $past(ins_s))
		else $error("HDLC bit 4 does not follow insert pin");

	chk_ohclk_pulse: assert property (
		take_warn |=> overhead_slot_clock [*4] ##1 !overhead_slot_clock)
		else $error("overhead clock pulse wrong length");

	chk_capture_data: assert property (
		cap |=> staged_vld[$past(cur_idx)]
			&& staged_val[$past(cur_idx)] == $past(dat_s))
		else $error("overhead data not captured at clock fall");

	chk_no_insert: assert property (
		fall_now && !ins_s |=> $stable(staged_val) || $past(frame_start))
		else $error("overhead data sampled with insert low");

	chk_every_slot: assert property (
		take_warn && !oh_warn.insertable |-> ##5 $fell(overhead_slot_clock))
		else $error("no overhead clock for non-insertable bit");

	chk_noins_ignored: assert property (
		fall_now && !cur_ins |-> !cap)
		else $error("non-insertable bit accepted");

	chk_armed_used: assert property (
		oh_proc.valid && ce && armed_vld[oh_proc.idx] |=> oh_tx.valid
			&& oh_tx.bit_val == $past(armed_val[oh_proc.idx]))
		else $error("accepted overhead bit not transmitted");

	chk_internal_used: assert property (
		oh_proc.valid && ce && !armed_vld[oh_proc.idx] |=>
			oh_tx.bit_val == $past(oh_proc.internal_bit))
		else $error("internal overhead value not transmitted");

	// =============================================================
	// checks on staging and shared pins
	// these guard paths that the directed scenarios see only through the outputs

	chk_low_no_cap: assert property (
		fall_now && !ins_s |-> !cap)
		else $error("capture with insert request low");

	chk_hdlc_no_cap: assert property (
		hdlc_enable |-> !cap)
		else $error("overhead capture while HDLC owns the insert pin");

	chk_pay_hold: assert property (
		!(nib_clk_rise && nib_active) |=> $stable(pay_out.bit3))
		else $error("nibble line 3 value changed without a sample");

	chk_hdlc_hold: assert property (
		!hdlc_enable |=> $stable(hdlc_out))
		else $error("HDLC bits changed while controller off");

	chk_frame_arm: assert property (
		ce && frame_start |=> armed_vld == $past(staged_vld)
			&& armed_val == $past(staged_val))
		else $error("staged overhead bits not armed at frame start");

	chk_stage_clear: assert property (
		ce && frame_start && !cap |=> staged_vld == '0)
		else $error("stage not cleared at frame start");

	chk_tx_single: assert property (
		ce && !oh_proc.valid |=> !oh_tx.valid)
		else $error("overhead bit sent without a request");

	cov_nibble: cover property (nib_clk_rise && nib_active);
	cov_capture: cover property (cap);
	cov_armed_tx: cover property (oh_proc.valid && armed_vld[oh_proc.idx]);
	cov_refused: cover property (fall_now && ins_s && !cur_ins);
	cov_hdlc_block: cover property (fall_now && ins_s && hdlc_enable);

endmodule

//--- tb/overhead_data_in_term.sv
module overhead_data_in_term (
	// commands from the bench
	input wire logic nib_run,
	input wire logic nib_val,
	input wire logic ins_arm,
	input wire logic ins_val,
	input wire logic hdlc_b4,
	// pins of the port
	input wire logic overhead_slot_clock,
	output logic nibble_sample_clock,
	output logic payload_nibble_line3,
	output logic overhead_insert_request,
	output logic overhead_data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ins_drive;
	initial begin
		ins_drive = 1'b0;
		nibble_sample_clock = 1'b0;
		payload_nibble_line3 = 1'b0;
		overhead_data_in = 1'b0;
	end
	// =============================================================
	// nibble clock runs only while payload is offered, else stands low
	always begin
		wait (nib_run);
		payload_nibble_line3 = nib_val;
		#200 nibble_sample_clock = 1'b1;
		#200 nibble_sample_clock = 1'b0;
	end
	always @(nib_val) begin
		if (!nib_run) begin
			payload_nibble_line3 = nib_val;
		end
	end
	// =============================================================
	// overhead insertion, held from slot clock rise until past its fall
	always @(posedge overhead_slot_clock) begin
		if (ins_arm) begin
			ins_drive = 1'b1;
			overhead_data_in = ins_val;
			@(negedge overhead_slot_clock);
			#150;
			ins_drive = 1'b0;
			// released data flips so a late sample cannot pass by luck
			overhead_data_in = ~ins_val;
		end
	end
	assign overhead_insert_request = ins_drive | hdlc_b4;
endmodule

//--- tb/tb_top.sv
`define CHECK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		err_count++; \
		$display("ERROR %0t: value mismatch", $time); \
	end \
end

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import overhead_data_in_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic nibble_mode = 1'b0;
	logic hdlc_enable = 1'b0;
	logic frame_start = 1'b0;
	overhead_data_in_warn_s oh_warn = '0;
	overhead_data_in_proc_s oh_proc = '0;
	logic nib_run = 1'b0;
	logic nib_val = 1'b0;
	logic ins_arm = 1'b0;
	logic ins_val = 1'b0;
	logic hdlc_b4 = 1'b0;
	// the send input sits outside this block; the bench still keeps it
	logic packet_send_hold = 1'b0;
	wire logic nclk, line3, ins_req, oh_data, slot_clk;
	overhead_data_in_oh_s oh_tx;
	overhead_data_in_pay_s pay_out;
	overhead_data_in_hdlc_s hdlc_out;
	int err_count = 0;
	int compares = 0;
	always #25 clock = ~clock;

	overhead_data_in_port dut (.clock(clock), .sys_rst(sys_rst), .ce(1'b1),
		.nibble_mode(nibble_mode), .hdlc_enable(hdlc_enable),
		.nibble_sample_clock(nclk), .payload_nibble_line3(line3),
		.overhead_insert_request(ins_req), .overhead_data_in(oh_data),
		.overhead_slot_clock(slot_clk), .oh_warn(oh_warn),
		.oh_proc(oh_proc), .frame_start(frame_start), .oh_tx(oh_tx),
		.pay_out(pay_out), .hdlc_out(hdlc_out));

	overhead_data_in_term term (.nib_run(nib_run), .nib_val(nib_val),
		.ins_arm(ins_arm), .ins_val(ins_val), .hdlc_b4(hdlc_b4),
		.overhead_slot_clock(slot_clk), .nibble_sample_clock(nclk),
		.payload_nibble_line3(line3), .overhead_insert_request(ins_req),
		.overhead_data_in(oh_data));

	// =============================================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic warn(input logic ins, input overhead_data_in_idx_t idx);
		oh_warn = '{valid: 1'b1, insertable: ins, idx: idx};
		tick(1);
		oh_warn = '0;
	endtask

	task automatic final_report();
		if (err_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// =============================================================
	// scenarios
	task automatic nib_case(input logic mode, input logic hd, input logic v);
		int seen;
		seen = 0;
		nibble_mode = mode;
		hdlc_enable = hd;
		nib_val = v;
		nib_run = 1'b1;
		for (int k = 0; k < 40; k++) begin
			tick(1);
			if (pay_out.valid === 1'b1) begin
				seen++;
				`CHECK(pay_out.bit3, v)
			end
		end
		nib_run = 1'b0;
		tick(10);
		`CHECK(seen >= 4, mode && !hd)
	endtask

	task automatic hdlc_case(input logic b3, input logic b4);
		packet_send_hold = 1'b1;
		hdlc_enable = 1'b1;
		nib_val = b3;
		hdlc_b4 = b4;
		tick(5);
		`CHECK(hdlc_out.bit3, b3)
		`CHECK(hdlc_out.bit4, b4)
		hdlc_enable = 1'b0;
		hdlc_b4 = 1'b0;
		packet_send_hold = 1'b0;
	endtask

	task automatic slot_case();
		`CHECK(slot_clk, 1'b0)
		warn(1'b0, 6'h03);
		for (int k = 0; k < 4; k++) begin
			`CHECK(slot_clk, 1'b1)
			tick(1);
		end
		`CHECK(slot_clk, 1'b0)
		tick(8);
	endtask

	task automatic oh_case(input logic insb, input logic arm, input logic v,
		input logic exp);
		ins_arm = arm;
		ins_val = v;
		warn(insb, 6'h07);
		tick(14);
		ins_arm = 1'b0;
		for (int f = 0; f < 2; f++) begin
			frame_start = 1'b1;
			tick(1);
			frame_start = 1'b0;
			oh_proc = '{valid: 1'b1, internal_bit: ~v, idx: 6'h07};
			tick(1);
			`CHECK(oh_tx.valid, 1'b1)
			`CHECK(oh_tx.bit_val, f ? ~v : exp)
			oh_proc = '0;
			tick(1);
		end
		tick(2);
	endtask

	// =============================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clock);
		#2;
		sys_rst = 1'b0;
		`CHECK(slot_clk, 1'b0)
		`CHECK(oh_tx.valid, 1'b0)
		tick(3);
		nib_case(1'b1, 1'b0, 1'b1);
		nib_case(1'b1, 1'b0, 1'b0);
		nib_case(1'b0, 1'b0, 1'b1);
		nib_case(1'b1, 1'b1, 1'b1);
		for (int c = 0; c < 4; c++) begin
			hdlc_case(c[0], c[1]);
		end
		slot_case();
		oh_case(1'b1, 1'b1, 1'b1, 1'b1);
		oh_case(1'b1, 1'b1, 1'b0, 1'b0);
		oh_case(1'b1, 1'b0, 1'b1, 1'b0);
		oh_case(1'b0, 1'b1, 1'b1, 1'b0);
		hdlc_enable = 1'b1;
		oh_case(1'b1, 1'b1, 1'b1, 1'b0);
		hdlc_enable = 1'b0;
		final_report();
	end
endmodule
